// >>> rtl/ptc_capture_slot.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptc_regs.svh"

module ptc_capture_slot (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic capture,
  input wire logic [31:0] stampIn,
  input wire logic clearReq,
  output logic [31:0] stamp,
  output logic flag
);

  logic [31:0] stamp_q;
  logic [31:0] stamp_d;
  logic flag_q;
  logic flag_d;

  always_comb
  begin
    stamp_d = stamp_q;
    flag_d = flag_q;
    if (clearReq)
    begin
      flag_d = 1'b0;
    end
    // newest frame wins; a capture beats a clear in the same cycle
    if (capture)
    begin
      stamp_d = stampIn;
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      stamp_q <= `PTC_STAMP_RESET;
      flag_q <= 1'b0;
    end
    else
    begin
      stamp_q <= stamp_d;
      flag_q <= flag_d;
    end
  end

  assign stamp = stamp_q;
  assign flag = flag_q;

endmodule : ptc_capture_slot
`default_nettype wire

// >>> rtl/ptc_corr_adjust.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptc_regs.svh"

module ptc_corr_adjust (
  input wire logic [63:0] corrIn,
  input wire logic [15:0] asymReg,
  input wire ptc_pkg::ptc_adj_type mode,
  output logic [63:0] corrOut
);

  logic [63:0] magScaled;
  logic [63:0] signedAsym;

  always_comb
  begin
    // correction field counts 2^-16 ns, so the ns magnitude is shifted up
    magScaled = {33'h0_0000_0000, asymReg[`PTC_ASYM_MAG_MSB:0], 16'h0000};
    // negative sign turns the magnitude into its two's complement
    signedAsym = asymReg[`PTC_ASYM_SIGN_BIT] ? (64'h0 - magScaled) : magScaled;
    unique case (mode)
      ptc_pkg::PTC_ADJ_ADD: corrOut = corrIn + signedAsym;
      ptc_pkg::PTC_ADJ_SUB: corrOut = corrIn - signedAsym;
      ptc_pkg::PTC_ADJ_PASS: corrOut = corrIn;
      default: corrOut = corrIn;
    endcase
  end

endmodule : ptc_corr_adjust
`default_nettype wire

// >>> rtl/ptc_pkg.sv
package ptc_pkg;

  typedef enum logic [3:0] {
    PTC_MSG_SYNC = 4'h0,
    PTC_MSG_DELAY_REQ = 4'h1,
    PTC_MSG_PDELAY_REQ = 4'h2,
    PTC_MSG_PDELAY_RESP = 4'h3,
    PTC_MSG_FOLLOW_UP = 4'h8,
    PTC_MSG_DELAY_RESP = 4'h9,
    PTC_MSG_PDELAY_RESP_FU = 4'ha,
    PTC_MSG_ANNOUNCE = 4'hb,
    PTC_MSG_SIGNALING = 4'hc,
    PTC_MSG_MANAGEMENT = 4'hd
  } ptc_msg_type;

  typedef enum logic [1:0] {
    PTC_CLASS_REQ = 2'b00,
    PTC_CLASS_SYNC = 2'b01,
    PTC_CLASS_RESP = 2'b10
  } ptc_class_type;

  typedef enum logic [1:0] {
    PTC_ADJ_PASS = 2'b00,
    PTC_ADJ_ADD = 2'b01,
    PTC_ADJ_SUB = 2'b10
  } ptc_adj_type;

endpackage : ptc_pkg

// >>> rtl/ptc_regs.svh
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH

`define PTC_ADDR_ASYM 16'hc04
`define PTC_ADDR_REQ_HI 16'hc08
`define PTC_ADDR_REQ_LO 16'hc0a
`define PTC_ADDR_SYNC_HI 16'hc0c
`define PTC_ADDR_SYNC_LO 16'hc0e
`define PTC_ADDR_RESP_HI 16'hc10
`define PTC_ADDR_RESP_LO 16'hc12
`define PTC_ADDR_FLAGS 16'hc14
`define PTC_ADDR_ENABLE 16'hc16

`define PTC_ASYM_SIGN_BIT 15
`define PTC_ASYM_MAG_MSB 14
`define PTC_SYNC_BIT 15
`define PTC_REQ_BIT 14
`define PTC_RESP_BIT 13

`define PTC_ASYM_RESET 16'h0000
`define PTC_STAMP_RESET 32'h0000_0000
`define PTC_ENABLE_RESET 3'h0
`define PTC_CORR_FRAC_BITS 16

`endif

// >>> rtl/ptc_top.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_regs.svh"

module ptc_top (
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWrEn,
  input wire logic busRdEn,
  output logic [15:0] busRdData,
  // correction field path
  input wire logic corrValid,
  input wire logic corrEgress,
  input wire ptc_pkg::ptc_msg_type corrMsgType,
  input wire logic [63:0] corrIn,
  output logic corrOutValid,
  output logic [63:0] corrOut,
  // egress timestamp capture
  input wire logic txStampValid,
  input wire ptc_pkg::ptc_class_type txStampClass,
  input wire logic [31:0] txStamp,
  // port-level indications
  output logic ptpIrqStatus,
  output logic ptpIrqEnable
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic hitAsym;
  logic hitReqHi;
  logic hitReqLo;
  logic hitSyncHi;
  logic hitSyncLo;
  logic hitRespHi;
  logic hitRespLo;
  logic hitFlags;
  logic hitEnable;

  always_comb
  begin
    hitAsym = (busAddr == `PTC_ADDR_ASYM);
    hitReqHi = (busAddr == `PTC_ADDR_REQ_HI);
    hitReqLo = (busAddr == `PTC_ADDR_REQ_LO);
    hitSyncHi = (busAddr == `PTC_ADDR_SYNC_HI);
    hitSyncLo = (busAddr == `PTC_ADDR_SYNC_LO);
    hitRespHi = (busAddr == `PTC_ADDR_RESP_HI);
    hitRespLo = (busAddr == `PTC_ADDR_RESP_LO);
    hitFlags = (busAddr == `PTC_ADDR_FLAGS);
    hitEnable = (busAddr == `PTC_ADDR_ENABLE);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // asymmetry and enable registers

  logic [15:0] asym_q;
  logic [15:0] asym_d;
  logic [2:0] enable_q;
  logic [2:0] enable_d;

  always_comb
  begin
    asym_d = asym_q;
    enable_d = enable_q;
    if (busWrEn && hitAsym)
    begin
      asym_d = busWrData;
    end
    if (busWrEn && hitEnable)
    begin
      enable_d = busWrData[`PTC_SYNC_BIT:`PTC_RESP_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      asym_q <= `PTC_ASYM_RESET;
      enable_q <= `PTC_ENABLE_RESET;
    end
    else
    begin
      asym_q <= asym_d;
      enable_q <= enable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // correction field adjust

  ptc_pkg::ptc_adj_type adjMode;
  logic [63:0] corrAdjusted;
  logic corrOutValid_q;
  logic corrOutValid_d;
  logic [63:0] corrOut_q;
  logic [63:0] corrOut_d;

  always_comb
  begin
    adjMode = ptc_pkg::PTC_ADJ_PASS;
    unique case (corrMsgType)
      ptc_pkg::PTC_MSG_SYNC,
      ptc_pkg::PTC_MSG_PDELAY_RESP:
      begin
        if (!corrEgress)
        begin
          adjMode = ptc_pkg::PTC_ADJ_ADD;
        end
      end
      ptc_pkg::PTC_MSG_DELAY_REQ,
      ptc_pkg::PTC_MSG_PDELAY_REQ:
      begin
        if (corrEgress)
        begin
          adjMode = ptc_pkg::PTC_ADJ_SUB;
        end
      end
      ptc_pkg::PTC_MSG_FOLLOW_UP,
      ptc_pkg::PTC_MSG_DELAY_RESP,
      ptc_pkg::PTC_MSG_PDELAY_RESP_FU,
      ptc_pkg::PTC_MSG_ANNOUNCE,
      ptc_pkg::PTC_MSG_SIGNALING,
      ptc_pkg::PTC_MSG_MANAGEMENT:
      begin
        adjMode = ptc_pkg::PTC_ADJ_PASS;
      end
      default:
      begin
        adjMode = ptc_pkg::PTC_ADJ_PASS;
      end
    endcase
  end

  ptc_corr_adjust u_adjust (
    .corrIn(corrIn),
    .asymReg(asym_q),
    .mode(adjMode),
    .corrOut(corrAdjusted)
  );

  always_comb
  begin
    corrOutValid_d = corrValid;
    corrOut_d = corrOut_q;
    if (corrValid)
    begin
      corrOut_d = corrAdjusted;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      corrOutValid_q <= 1'b0;
      corrOut_q <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      corrOutValid_q <= corrOutValid_d;
      corrOut_q <= corrOut_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // egress timestamp capture slots

  logic capReq;
  logic capSync;
  logic capResp;
  logic clrReq;
  logic clrSync;
  logic clrResp;
  logic [31:0] stampReq;
  logic [31:0] stampSync;
  logic [31:0] stampResp;
  logic reqTimeReadyFlag;
  logic syncTimeReadyFlag;
  logic respTimeReadyFlag;

  always_comb
  begin
    capReq = 1'b0;
    capSync = 1'b0;
    capResp = 1'b0;
    if (txStampValid)
    begin
      unique case (txStampClass)
        ptc_pkg::PTC_CLASS_REQ: capReq = 1'b1;
        ptc_pkg::PTC_CLASS_SYNC: capSync = 1'b1;
        ptc_pkg::PTC_CLASS_RESP: capResp = 1'b1;
        default:
        begin
          capReq = 1'b0;
        end
      endcase
    end
    // write-one-to-clear, zeros leave flags alone
    clrSync = busWrEn && hitFlags && busWrData[`PTC_SYNC_BIT];
    clrReq = busWrEn && hitFlags && busWrData[`PTC_REQ_BIT];
    clrResp = busWrEn && hitFlags && busWrData[`PTC_RESP_BIT];
  end

  ptc_capture_slot u_slot_req (
    .clock(clock),
    .sys_rst(sys_rst),
    .capture(capReq),
    .stampIn(txStamp),
    .clearReq(clrReq),
    .stamp(stampReq),
    .flag(reqTimeReadyFlag)
  );

  ptc_capture_slot u_slot_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .capture(capSync),
    .stampIn(txStamp),
    .clearReq(clrSync),
    .stamp(stampSync),
    .flag(syncTimeReadyFlag)
  );

  ptc_capture_slot u_slot_resp (
    .clock(clock),
    .sys_rst(sys_rst),
    .capture(capResp),
    .stampIn(txStamp),
    .clearReq(clrResp),
    .stamp(stampResp),
    .flag(respTimeReadyFlag)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // port-level indications

  logic irqStatus_q;
  logic irqStatus_d;
  logic irqEnable_q;
  logic irqEnable_d;

  always_comb
  begin
    irqStatus_d = syncTimeReadyFlag | reqTimeReadyFlag | respTimeReadyFlag;
    irqEnable_d = |enable_q;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      irqStatus_q <= 1'b0;
      irqEnable_q <= 1'b0;
    end
    else
    begin
      irqStatus_q <= irqStatus_d;
      irqEnable_q <= irqEnable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe, zero elsewhere

  logic [15:0] rdData_q;
  logic [15:0] rdData_d;

  always_comb
  begin
    rdData_d = 16'h0000;
    if (busRdEn)
    begin
      if (hitAsym)
      begin
        rdData_d = asym_q;
      end
      else if (hitReqHi)
      begin
        rdData_d = stampReq[31:16];
      end
      else if (hitReqLo)
      begin
        rdData_d = stampReq[15:0];
      end
      else if (hitSyncHi)
      begin
        rdData_d = stampSync[31:16];
      end
      else if (hitSyncLo)
      begin
        rdData_d = stampSync[15:0];
      end
      else if (hitRespHi)
      begin
        rdData_d = stampResp[31:16];
      end
      else if (hitRespLo)
      begin
        rdData_d = stampResp[15:0];
      end
      else if (hitFlags)
      begin
        rdData_d = {syncTimeReadyFlag, reqTimeReadyFlag, respTimeReadyFlag, 13'h0000};
      end
      else if (hitEnable)
      begin
        rdData_d = {enable_q, 13'h0000};
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rdData_q <= 16'h0000;
    end
    else
    begin
      rdData_q <= rdData_d;
    end
  end

  assign busRdData = rdData_q;
  assign corrOutValid = corrOutValid_q;
  assign corrOut = corrOut_q;
  assign ptpIrqStatus = irqStatus_q;
  assign ptpIrqEnable = irqEnable_q;

endmodule : ptc_top
`default_nettype wire

// >>> testbench/ptc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptc_regs.svh"
module ptc_top_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [15:0] busAddr,
  input wire logic busWrEn,
  input wire logic busRdEn,
  input wire logic [15:0] busRdData,
  input wire logic corrValid,
  input wire logic corrEgress,
  input wire ptc_pkg::ptc_msg_type corrMsgType,
  input wire logic [63:0] corrIn,
  input wire logic corrOutValid,
  input wire logic [63:0] corrOut,
  input wire logic txStampValid,
  input wire ptc_pkg::ptc_class_type txStampClass,
  input wire logic ptpIrqStatus,
  input wire logic ptpIrqEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic hit;
  // message that gets the asymmetry applied
  assign hit = corrEgress ? (corrMsgType == 4'h1 || corrMsgType == 4'h2) :
    (corrMsgType == 4'h0 || corrMsgType == 4'h3);
  rd_idle_a: assert property (!busRdEn |=> busRdData == 16'h0)
    else $error("read data not idle");
  corr_ans_a: assert property (corrValid |=> corrOutValid)
    else $error("no correction answer");
  corr_quiet_a: assert property (!corrValid |=> !corrOutValid && $stable(corrOut))
    else $error("correction output moved");
  corr_pass_a: assert property (corrValid && !hit |=> corrOut == $past(corrIn))
    else $error("passing message altered");
  cap_flag_a: assert property (txStampValid && txStampClass != 2'b11 |-> ##2 ptpIrqStatus)
    else $error("capture raised no status");
  stat_rise_a: assert property ($rose(ptpIrqStatus) |->
    $past(txStampValid, 2) && $past(txStampClass, 2) != 2'b11)
    else $error("status rose without capture");
  // a reset edge also drops the registered indications
  stat_fall_a: assert property ($fell(ptpIrqStatus) |-> $past(sys_rst) ||
    ($past(busWrEn, 2) && $past(busAddr, 2) == `PTC_ADDR_FLAGS))
    else $error("status fell without clear");
  en_chg_a: assert property ($changed(ptpIrqEnable) |-> $past(sys_rst) ||
    ($past(busWrEn, 2) && $past(busAddr, 2) == `PTC_ADDR_ENABLE))
    else $error("enable moved without write");
  cover property (txStampValid ##2 ptpIrqStatus);
  cover property ($fell(ptpIrqStatus));
  cover property (corrValid && hit ##1 corrOutValid);
endmodule : ptc_top_chk
bind ptc_top ptc_top_chk chk (.clock, .sys_rst, .busAddr, .busWrEn, .busRdEn, .busRdData,
  .corrValid, .corrEgress, .corrMsgType, .corrIn, .corrOutValid, .corrOut, .txStampValid,
  .txStampClass, .ptpIrqStatus, .ptpIrqEnable);
`default_nettype wire

// >>> testbench/ptc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptc_regs.svh"
module ptc_top_tb_top;
  logic clock = 0;
  logic sys_rst = 1;
  logic [15:0] busAddr = 0;
  logic [15:0] busWrData = 0;
  logic busWrEn = 0;
  logic busRdEn = 0;
  logic [15:0] busRdData;
  logic corrValid = 0;
  logic corrEgress = 0;
  ptc_pkg::ptc_msg_type corrMsgType = ptc_pkg::PTC_MSG_SYNC;
  logic [63:0] corrIn = 0;
  logic corrOutValid;
  logic [63:0] corrOut;
  logic txStampValid = 0;
  ptc_pkg::ptc_class_type txStampClass = ptc_pkg::PTC_CLASS_REQ;
  logic [31:0] txStamp = 0;
  logic ptpIrqStatus;
  logic ptpIrqEnable;
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] st [3];
  logic [15:0] fl;
  logic [15:0] asym;
  logic [15:0] d;
  logic [3:0] tys [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8};

  ptc_top dut (.clock, .sys_rst, .busAddr, .busWrData, .busWrEn, .busRdEn, .busRdData,
    .corrValid, .corrEgress, .corrMsgType, .corrIn, .corrOutValid, .corrOut, .txStampValid,
    .txStampClass, .txStamp, .ptpIrqStatus, .ptpIrqEnable);

  initial
  begin
    forever #12.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check

  task final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  function int fb(input logic [1:0] c);
    return c == 2'd1 ? 15 : (c == 2'd0 ? 14 : 13);
  endfunction : fb

  function logic [15:0] ha(input int j);
    return 16'hc08 + 16'(4 * j);
  endfunction : ha

  function logic [63:0] adj(input logic e, input logic [3:0] ty, input logic [63:0] x);
    logic [63:0] m;
    m = {33'h0, asym[14:0], 16'h0};
    if (asym[15])
      m = -m;
    if (!e && (ty == 4'h0 || ty == 4'h3))
      return x + m;
    if (e && (ty == 4'h1 || ty == 4'h2))
      return x - m;
    return x;
  endfunction : adj

  task wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clock);
    busAddr <= a;
    busWrData <= v;
    busWrEn <= 1'b1;
    @(posedge clock);
    busWrEn <= 1'b0;
  endtask : wr

  task rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clock);
    busAddr <= a;
    busRdEn <= 1'b1;
    @(posedge clock);
    busRdEn <= 1'b0;
    #1 check(64'(busRdData), 64'(e));
  endtask : rd

  task cap(input logic [1:0] c, input logic [31:0] t);
    @(posedge clock);
    txStampValid <= 1'b1;
    txStampClass <= ptc_pkg::ptc_class_type'(c);
    txStamp <= t;
    @(posedge clock);
    txStampValid <= 1'b0;
    if (c != 2'd3)
    begin
      st[c] = t;
      fl[fb(c)] = 1'b1;
    end
  endtask : cap

  task cor(input logic e, input logic [3:0] ty, input logic [63:0] x);
    @(posedge clock);
    corrValid <= 1'b1;
    corrEgress <= e;
    corrMsgType <= ptc_pkg::ptc_msg_type'(ty);
    corrIn <= x;
    @(posedge clock);
    corrValid <= 1'b0;
    #1 check(64'(corrOutValid), 64'h1);
    check(corrOut, adj(e, ty, x));
  endtask : cor

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h7c070fe0));
    fl = 16'h0;
    asym = 16'h0;
    st = '{default: 32'h0};
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 16'hc02; a <= 16'hc18; a += 2)
      rd(16'(a), 16'h0);
    for (int k = 0; k < 3; k++)
    begin
      asym = (k == 2) ? 16'hffff : {k[0], 15'($urandom)};
      wr(`PTC_ADDR_ASYM, asym);
      rd(`PTC_ADDR_ASYM, asym);
      foreach (tys[i])
        for (int e = 0; e < 2; e++)
          cor(e[0], tys[i], {$urandom, $urandom});
    end
    for (int r = 0; r < 10; r++)
    begin
      cap(r < 4 ? 2'(r) : 2'($urandom), $urandom);
      wr(16'hc0e, 16'($urandom));
      for (int j = 0; j < 3; j++)
      begin
        rd(ha(j), st[j][31:16]);
        rd(ha(j) + 16'h2, st[j][15:0]);
      end
      rd(`PTC_ADDR_FLAGS, fl);
      check(64'(ptpIrqStatus), 64'(|fl));
    end
    wr(`PTC_ADDR_FLAGS, 16'h0);
    rd(`PTC_ADDR_FLAGS, fl);
    for (int b = 13; b < 16; b++)
    begin
      wr(`PTC_ADDR_FLAGS, 16'h1 << b);
      fl[b] = 1'b0;
      rd(`PTC_ADDR_FLAGS, fl);
      check(64'(ptpIrqStatus), 64'(|fl));
    end
    // capture and clear of the same flag in one cycle: set wins
    fork
      cap(2'd1, 32'h0123_4567);
      wr(`PTC_ADDR_FLAGS, 16'h8000);
    join
    rd(`PTC_ADDR_FLAGS, fl);
    rd(`PTC_ADDR_SYNC_HI, 16'h0123);
    check(64'(ptpIrqStatus), 64'h1);
    for (int r = 0; r < 5; r++)
    begin
      d = (r == 0) ? 16'he000 : 16'($urandom);
      wr(`PTC_ADDR_ENABLE, d);
      rd(`PTC_ADDR_ENABLE, d & 16'he000);
      check(64'(ptpIrqEnable), 64'(|d[15:13]));
    end
    // second reset mid-run clears the enables again
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    rd(`PTC_ADDR_ENABLE, 16'h0);
    final_report();
  end

  initial
  begin
    #100us;
    n_errors++;
    final_report();
  end
endmodule : ptc_top_tb_top
`default_nettype wire
